// ---- hdl/fks_sequencer.sv ----
// Flash self-programming controller: registers, key lock, move-write redirect and flash engine.
`timescale 1ns/1ns
`default_nettype none
`include "fks_consts.svh"

module fks_sequencer
  import fks_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mv_wr,
  input wire logic [15:0] mv_addr,
  input wire logic [7:0] mv_data,
  output logic mv_ready,
  output logic [15:0] xram_addr,
  output logic [7:0] xram_wdata,
  output logic xram_we,
  input wire logic [7:0] fl_rdata,
  output logic [17:0] fl_addr,
  output logic [7:0] fl_wdata,
  output logic fl_we,
  output logic erase_write_timing_bit
);
  // ----------------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------------
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_take;
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [1:0] code_bank_select;
  logic [1:0] bank_next;
  logic timing_reg;
  logic timing_next;
  logic key_wr;
  logic unlocked;
  logic first_seen;
  logic locked_out;
  logic busy;
  logic store_write_enable;
  logic store_erase_enable;

  // True when a bus write to the given offset is taken with the low lane enabled.
  function automatic logic fks_hit(input logic [4:0] ofs, input logic [4:0] adr, input logic take,
                                   input logic lane);
    fks_hit = take && lane && (adr == ofs);
  endfunction

  // Every request waits exactly one cycle with ce high, longer while ce is low; the answer is taken when waitrequest drops.
  always_comb
  begin
    ack_next = (avs_read || avs_write) && !ack_reg;
    rdata_next = 32'h00000000;
    unique case (avs_address)
      `FKS_OFS_CTRL: rdata_next[1:0] = ctrl_reg;
      `FKS_OFS_BANK: rdata_next[1:0] = code_bank_select;
      `FKS_OFS_TIMING: rdata_next[0] = timing_reg;
      `FKS_OFS_STATUS:
      begin
        rdata_next[`FKS_STAT_OPEN_BIT] = unlocked;
        rdata_next[`FKS_STAT_HALF_BIT] = first_seen;
        rdata_next[`FKS_STAT_DEAD_BIT] = locked_out;
        rdata_next[`FKS_STAT_BUSY_BIT] = busy;
      end
      default: rdata_next = 32'h00000000;
    endcase
    if (!avs_read)
      rdata_next = rdata_reg;
  end

  // Registers the bus handshake and read data.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign wr_take = avs_write && ack_reg && ce;
  assign key_wr = fks_hit(`FKS_OFS_KEY, avs_address, wr_take, avs_byteenable[0]);

  // ----------------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------------
  // Only software writes change these bits; no flash operation touches them.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    bank_next = code_bank_select;
    timing_next = timing_reg;
    if (fks_hit(`FKS_OFS_CTRL, avs_address, wr_take, avs_byteenable[0]))
      ctrl_next = avs_writedata[1:0];
    if (fks_hit(`FKS_OFS_BANK, avs_address, wr_take, avs_byteenable[0]))
      bank_next = avs_writedata[1:0];
    if (fks_hit(`FKS_OFS_TIMING, avs_address, wr_take, avs_byteenable[0]))
      timing_next = avs_writedata[`FKS_TIMING_EWT_BIT];
  end

  // Registers the control bits.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= `FKS_CTRL_RESET;
      code_bank_select <= `FKS_BANK_RESET;
      timing_reg <= `FKS_TIMING_RESET;
    end
    else if (ce)
    begin
      ctrl_reg <= ctrl_next;
      code_bank_select <= bank_next;
      timing_reg <= timing_next;
    end
  end

  assign store_write_enable = ctrl_reg[`FKS_CTRL_WEN_BIT];
  assign store_erase_enable = ctrl_reg[`FKS_CTRL_EEN_BIT];
  assign erase_write_timing_bit = timing_reg;

  // ----------------------------------------------------------------------------
  // Move-write routing
  // ----------------------------------------------------------------------------
  logic mv_take;
  logic flash_try;
  logic flash_go;
  logic xram_we_reg;
  logic xram_we_next;
  logic [15:0] xram_addr_reg;
  logic [15:0] xram_addr_next;
  logic [7:0] xram_wdata_reg;
  logic [7:0] xram_wdata_next;

  assign mv_ready = !busy;
  assign mv_take = mv_wr && mv_ready && ce;
  assign flash_try = mv_take && store_write_enable;
  assign flash_go = flash_try && unlocked;

  // Writes with the enable clear go to data memory as before.
  always_comb
  begin
    xram_we_next = mv_take && !store_write_enable;
    xram_addr_next = xram_addr_reg;
    xram_wdata_next = xram_wdata_reg;
    if (xram_we_next)
    begin
      xram_addr_next = mv_addr;
      xram_wdata_next = mv_data;
    end
  end

  // Registers the data-memory write.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xram_we_reg <= 1'b0;
      xram_addr_reg <= 16'h0000;
      xram_wdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      xram_we_reg <= xram_we_next;
      xram_addr_reg <= xram_addr_next;
      xram_wdata_reg <= xram_wdata_next;
    end
  end

  assign xram_we = xram_we_reg;
  assign xram_addr = xram_addr_reg;
  assign xram_wdata = xram_wdata_reg;

  // ----------------------------------------------------------------------------
  // Key checker and flash engine
  // ----------------------------------------------------------------------------
  // Any redirected write counts as an attempt; the checker relocks or locks out.
  fks_key_check u_key
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .key_wr(key_wr),
    .key_data(avs_writedata[7:0]),
    .op_try(flash_try),
    .unlocked(unlocked),
    .first_seen(first_seen),
    .locked_out(locked_out)
  );

  // The bank field widens the move address to reach the upper code banks.
  fks_flash_engine u_eng
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .start(flash_go),
    .erase(store_erase_enable),
    .addr({code_bank_select, mv_addr}),
    .data(mv_data),
    .fl_rdata(fl_rdata),
    .fl_addr(fl_addr),
    .fl_wdata(fl_wdata),
    .fl_we(fl_we),
    .busy(busy)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_redirect;
    @(posedge clk_sys) disable iff (!reset_n)
    mv_take && store_write_enable |=> !xram_we;
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirected write reached data memory");

  property p_plain_write;
    @(posedge clk_sys) disable iff (!reset_n)
    mv_take && !store_write_enable |=> xram_we && xram_addr == $past(mv_addr);
  endproperty
  a_plain_write: assert property (p_plain_write) else $error("data memory write was lost");

  property p_wen_sticky;
    @(posedge clk_sys) disable iff (!reset_n)
    store_write_enable && !wr_take |=> store_write_enable;
  endproperty
  a_wen_sticky: assert property (p_wen_sticky) else $error("write enable cleared by hardware");

  property p_erase_page;
    @(posedge clk_sys) disable iff (!reset_n)
    flash_go && store_erase_enable ##1 ce |-> fl_we && fl_addr[8:0] == 9'h000 && fl_addr[17:9] == $past(
      {code_bank_select, mv_addr[15:9]});
  endproperty
  a_erase_page: assert property (p_erase_page) else $error("erase did not start at page base");

  property p_program_byte;
    @(posedge clk_sys) disable iff (!reset_n)
    flash_go && !store_erase_enable ##1 ce[*3] |-> fl_we && fl_addr == $past({code_bank_select, mv_addr}, 3);
  endproperty
  a_program_byte: assert property (p_program_byte) else $error("program hit the wrong byte");

  property p_wait_once;
    @(posedge clk_sys) disable iff (!reset_n)
    avs_waitrequest && ce |=> !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("waitrequest held over one cycle");
endmodule
`default_nettype wire

// ---- inc/fks_consts.svh ----
// Offsets, field positions, key codes and reset values of the flash lock and key sequencer.
`ifndef FKS_CONSTS_SVH
`define FKS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FKS_OFS_CTRL 5'h00
`define FKS_OFS_KEY 5'h04
`define FKS_OFS_BANK 5'h08
`define FKS_OFS_TIMING 5'h0c
`define FKS_OFS_STATUS 5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FKS_CTRL_WEN_BIT 0
`define FKS_CTRL_EEN_BIT 1
`define FKS_TIMING_EWT_BIT 0
`define FKS_STAT_OPEN_BIT 0
`define FKS_STAT_HALF_BIT 1
`define FKS_STAT_DEAD_BIT 2
`define FKS_STAT_BUSY_BIT 3

// ----------------------------------------------------------------------------
// Key codes, page geometry and reset values
// ----------------------------------------------------------------------------
`define FKS_KEY_FIRST 8'ha5
`define FKS_KEY_SECOND 8'hf1
`define FKS_PAGE_BITS 9
`define FKS_PAGE_LAST 9'h1ff
`define FKS_ERASED_BYTE 8'hff
`define FKS_CTRL_RESET 2'h0
`define FKS_BANK_RESET 2'h0
`define FKS_TIMING_RESET 1'h0

`endif

// ---- inc/fks_pkg.sv ----
// Types shared by the flash lock and key sequencer modules.
`default_nettype none
package fks_pkg;
  typedef enum logic [1:0] {FKS_KEY_IDLE, FKS_KEY_HALF, FKS_KEY_OPEN, FKS_KEY_DEAD} fks_key_state_t;
  typedef enum logic [2:0] {FKS_ENG_IDLE, FKS_ENG_READ, FKS_ENG_WAIT, FKS_ENG_WRITE, FKS_ENG_ERASE} fks_eng_state_t;
endpackage
`default_nettype wire

// ---- hdl/fks_key_check.sv ----
// Two-code key checker with a sticky lockout that only reset clears.
`timescale 1ns/1ns
`default_nettype none
`include "fks_consts.svh"
module fks_key_check
  import fks_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic op_try,
  output logic unlocked,
  output logic first_seen,
  output logic locked_out
);
  fks_key_state_t state_reg;
  fks_key_state_t state_next;

  // ----------------------------------------------------------------------------
  // Key sequence
  // ----------------------------------------------------------------------------
  // Next state; there is no timer, so a half-entered sequence waits for ever.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      FKS_KEY_IDLE:
      begin
        if (op_try)
          state_next = FKS_KEY_DEAD;
        else if (key_wr)
          state_next = (key_data == `FKS_KEY_FIRST) ? FKS_KEY_HALF : FKS_KEY_DEAD;
      end
      FKS_KEY_HALF:
      begin
        if (op_try)
          state_next = FKS_KEY_DEAD;
        else if (key_wr)
          state_next = (key_data == `FKS_KEY_SECOND) ? FKS_KEY_OPEN : FKS_KEY_DEAD;
      end
      FKS_KEY_OPEN:
      begin
        if (op_try)
          state_next = FKS_KEY_IDLE;
        else if (key_wr)
          state_next = FKS_KEY_DEAD;
      end
      FKS_KEY_DEAD:
        state_next = FKS_KEY_DEAD;
    endcase
  end

  // Registers the state; reset relocks and clears the lockout.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= FKS_KEY_IDLE;
    else if (ce)
      state_reg <= state_next;
  end

  assign unlocked = (state_reg == FKS_KEY_OPEN);
  assign first_seen = (state_reg == FKS_KEY_HALF);
  assign locked_out = (state_reg == FKS_KEY_DEAD);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_wrong_key;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && key_wr && !op_try && !locked_out && !(first_seen && key_data == `FKS_KEY_SECOND)
      && !(!first_seen && !unlocked && key_data == `FKS_KEY_FIRST) |=> locked_out;
  endproperty
  a_wrong_key: assert property (p_wrong_key) else $error("wrong key did not lock out");

  property p_early_try;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && op_try && !unlocked |=> locked_out ##1 locked_out;
  endproperty
  a_early_try: assert property (p_early_try) else $error("early flash write did not lock out");

  property p_no_timeout;
    @(posedge clk_sys) disable iff (!reset_n)
    first_seen && !key_wr && !op_try |=> first_seen;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("half sequence was dropped");

  property p_relock;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && unlocked && op_try |=> !unlocked && !locked_out;
  endproperty
  a_relock: assert property (p_relock) else $error("key did not relock after operation");
endmodule
`default_nettype wire

// ---- hdl/fks_flash_engine.sv ----
// Flash byte program (read, AND, write) and 512-byte page erase sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "fks_consts.svh"
module fks_flash_engine
  import fks_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic start,
  input wire logic erase,
  input wire logic [17:0] addr,
  input wire logic [7:0] data,
  input wire logic [7:0] fl_rdata,
  output logic [17:0] fl_addr,
  output logic [7:0] fl_wdata,
  output logic fl_we,
  output logic busy
);
  fks_eng_state_t state_reg;
  fks_eng_state_t state_next;
  logic [17:0] addr_reg;
  logic [17:0] addr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic we_reg;
  logic we_next;

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // Program reads the old byte first so bits can only fall; erase walks the page.
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    wdata_next = wdata_reg;
    we_next = 1'b0;
    unique case (state_reg)
      FKS_ENG_IDLE:
      begin
        if (start && erase)
        begin
          state_next = FKS_ENG_ERASE;
          addr_next = {addr[17:`FKS_PAGE_BITS], {`FKS_PAGE_BITS{1'b0}}};
          wdata_next = `FKS_ERASED_BYTE;
          we_next = 1'b1;
        end
        else if (start)
        begin
          state_next = FKS_ENG_READ;
          addr_next = addr;
          data_next = data;
        end
      end
      FKS_ENG_READ:
        state_next = FKS_ENG_WAIT;
      FKS_ENG_WAIT:
      begin
        state_next = FKS_ENG_WRITE;
        wdata_next = fl_rdata & data_reg;
        we_next = 1'b1;
      end
      FKS_ENG_WRITE:
        state_next = FKS_ENG_IDLE;
      FKS_ENG_ERASE:
      begin
        if (addr_reg[`FKS_PAGE_BITS-1:0] == `FKS_PAGE_LAST)
          state_next = FKS_ENG_IDLE;
        else
        begin
          addr_next = addr_reg + 18'h00001;
          we_next = 1'b1;
        end
      end
      default:
        state_next = FKS_ENG_IDLE;
    endcase
  end

  // Registers the sequencer.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= FKS_ENG_IDLE;
      addr_reg <= 18'h00000;
      data_reg <= 8'h00;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
    end
  end

  assign fl_addr = addr_reg;
  assign fl_wdata = wdata_reg;
  assign fl_we = we_reg && ce;
  assign busy = (state_reg != FKS_ENG_IDLE);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_only_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    state_reg == FKS_ENG_WAIT && ce ##1 ce |-> fl_we && ((fl_wdata & ~$past(fl_rdata)) == 8'h00);
  endproperty
  a_only_clear: assert property (p_only_clear) else $error("program raised a bit");

  property p_erase_fill;
    @(posedge clk_sys) disable iff (!reset_n)
    state_reg == FKS_ENG_ERASE && ce |-> fl_wdata == 8'hff && fl_we;
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("erase wrote a non-blank byte");
endmodule
`default_nettype wire

// ---- tb/fks_flash_model.sv ----
// Behavioural flash array that answers the sequencer's flash port.
`timescale 1ns/1ns
`default_nettype none
module fks_flash_model
(
  input wire logic clk_sys,
  input wire logic [17:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_we,
  output logic [7:0] fl_rdata
);
  logic [7:0] mem [0:262143];
  // Fills the array with an address pattern so that AND results differ from plain writes.
  initial
  begin
    for (int i = 0; i < 262144; i++)
    begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'(i >> 16) ^ 8'h3c;
    end
  end
  // Stores a written byte as given and returns the addressed byte one cycle later.
  always @(posedge clk_sys)
  begin
    if (fl_we)
    begin
      mem[fl_addr] <= fl_wdata;
    end
    fl_rdata <= mem[fl_addr];
  end
endmodule
`default_nettype wire

// ---- tb/fks_sequencer_tb_top.sv ----
// Self-checking testbench of the flash lock and key sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "fks_consts.svh"
module fks_sequencer_tb_top
  import fks_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic mv_wr = 1'b0;
  logic [15:0] mv_addr = 16'h0;
  logic [7:0] mv_data = 8'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, mv_ready, xram_we, fl_we, ewt, xw;
  logic [15:0] xram_addr;
  logic [7:0] xram_wdata, fl_rdata, fl_wdata, d, old, keep;
  logic [17:0] fl_addr, fa;
  logic [15:0] rnd = 16'ha4f8;
  logic [15:0] bad [4] = '{16'h0012, 16'h00f1, 16'ha5a5, 16'ha500};
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;

  fks_sequencer fks_sequencer_i (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mv_wr(mv_wr), .mv_addr(mv_addr),
    .mv_data(mv_data), .mv_ready(mv_ready), .xram_addr(xram_addr), .xram_wdata(xram_wdata), .xram_we(xram_we),
    .fl_rdata(fl_rdata), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we), .erase_write_timing_bit(ewt));
  fks_flash_model fks_flash_model_i (.clk_sys(clk_sys), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we),
    .fl_rdata(fl_rdata));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Compares a seen value with the expected one and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One Avalon transfer: the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // One move write from the core, then a bounded wait until the port is ready again.
  task automatic mv(input logic [15:0] a, input logic [7:0] dd);
    int n;
    n = 0;
    mv_addr <= a;
    mv_data <= dd;
    mv_wr <= 1'b1;
    @(posedge clk_sys);
    mv_wr <= 1'b0;
    @(posedge clk_sys);
    xw = xram_we;
    while (mv_ready !== 1'b1 && n < 600)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("mv_ready", {31'h0, mv_ready}, 32'h1);
  endtask

  task automatic reset_dut();
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  // Full software flow for one program or erase at flash address a.
  task automatic op(input logic [17:0] a, input logic [7:0] dd, input logic er);
    bus(1'b1, `FKS_OFS_BANK, {6'h0, a[17:16]}, 4'h1);
    bus(1'b1, `FKS_OFS_TIMING, 8'h01, 4'h1);
    check("timing_out", {31'h0, ewt}, 32'h1);
    bus(1'b1, `FKS_OFS_CTRL, {6'h0, er, 1'b1}, 4'h1);
    bus(1'b1, `FKS_OFS_KEY, `FKS_KEY_FIRST, 4'h1);
    rnd = lfsr_next(rnd);
    // A move write while the clock enable is low must be ignored, or it would lock the key out.
    ce <= 1'b0;
    mv_wr <= 1'b1;
    @(posedge clk_sys);
    mv_wr <= 1'b0;
    repeat (rnd[5:0]) @(posedge clk_sys);
    ce <= 1'b1;
    bus(1'b0, `FKS_OFS_STATUS, 8'h00, 4'hf);
    check("status_half", q, 32'h2);
    bus(1'b1, `FKS_OFS_KEY, `FKS_KEY_SECOND, 4'h1);
    bus(1'b0, `FKS_OFS_STATUS, 8'h00, 4'hf);
    check("status_open", q, 32'h1);
    mv(a[15:0], dd);
    check("xram_we_flash", {31'h0, xw}, 32'h0);
    bus(1'b0, `FKS_OFS_STATUS, 8'h00, 4'hf);
    check("status_relock", q, 32'h0);
    bus(1'b0, `FKS_OFS_CTRL, 8'h00, 4'hf);
    check("ctrl_kept", q, {30'h0, er, 1'b1});
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      $display("CHECK FAILED timeout expected finish seen hang");
      conclude();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    reset_dut();
    foreach (bad[i])
    begin
      bus(1'b0, 5'(i * 4), 8'h00, 4'hf);
      check("reset_value", q, 32'h0);
    end
    bus(1'b0, 5'h14, 8'h00, 4'hf);
    check("unmapped", q, 32'h0);
    bus(1'b1, `FKS_OFS_CTRL, 8'h01, 4'h0);
    bus(1'b0, `FKS_OFS_CTRL, 8'h00, 4'hf);
    check("no_lane_write", q, 32'h0);
    // Move writes reach data memory while write-enable is clear.
    repeat (4)
    begin
      rnd = lfsr_next(rnd);
      d = rnd[7:0] ^ rnd[15:8];
      mv(rnd, d);
      check("xram_we", {31'h0, xw}, 32'h1);
      check("xram_addr", {16'h0, xram_addr}, {16'h0, rnd});
      check("xram_wdata", {24'h0, xram_wdata}, {24'h0, d});
    end
    // Byte programs, twice at the same place, store the AND of old and new data.
    repeat (5)
    begin
      rnd = lfsr_next(rnd);
      fa = {rnd[15:14], 1'b0, rnd[14:0]};
      repeat (2)
      begin
        rnd = lfsr_next(rnd);
        d = rnd[7:0];
        old = fks_flash_model_i.mem[fa];
        op(fa, d, 1'b0);
        check("program", {24'h0, fks_flash_model_i.mem[fa]}, {24'h0, old & d});
      end
    end
    // Page erase clears exactly one 512-byte page.
    keep = fks_flash_model_i.mem[18'h0c200];
    old = fks_flash_model_i.mem[18'h0bfff];
    op(18'h0c123, 8'h00, 1'b1);
    check("erase_base", {24'h0, fks_flash_model_i.mem[18'h0c000]}, {24'h0, `FKS_ERASED_BYTE});
    check("erase_last", {24'h0, fks_flash_model_i.mem[18'h0c1ff]}, {24'h0, `FKS_ERASED_BYTE});
    check("erase_next", {24'h0, fks_flash_model_i.mem[18'h0c200]}, {24'h0, keep});
    check("erase_prev", {24'h0, fks_flash_model_i.mem[18'h0bfff]}, {24'h0, old});
    bus(1'b1, `FKS_OFS_CTRL, 8'h00, 4'h1);
    mv(16'hc050, 8'h5a);
    check("after_clear", {31'h0, xw}, 32'h1);
    op(18'h0c050, 8'h5a, 1'b0);
    check("erased_prog", {24'h0, fks_flash_model_i.mem[18'h0c050]}, 32'h5a);
    // A flash write before the keys locks flash out until reset.
    reset_dut();
    old = fks_flash_model_i.mem[18'h01234];
    bus(1'b1, `FKS_OFS_CTRL, 8'h01, 4'h1);
    mv(16'h1234, 8'h00);
    check("early_drop", {31'h0, xw}, 32'h0);
    bus(1'b0, `FKS_OFS_STATUS, 8'h00, 4'hf);
    check("early_lock", {31'h0, q[2]}, 32'h1);
    // Wrong codes or order lock out even a later correct sequence.
    foreach (bad[i])
    begin
      reset_dut();
      bus(1'b0, `FKS_OFS_STATUS, 8'h00, 4'hf);
      check("lock_cleared", q, 32'h0);
      if (bad[i][15:8] != 8'h00)
        bus(1'b1, `FKS_OFS_KEY, bad[i][15:8], 4'h1);
      bus(1'b1, `FKS_OFS_KEY, bad[i][7:0], 4'h1);
      bus(1'b0, `FKS_OFS_STATUS, 8'h00, 4'hf);
      check("bad_key_lock", {31'h0, q[2]}, 32'h1);
      bus(1'b1, `FKS_OFS_KEY, `FKS_KEY_FIRST, 4'h1);
      bus(1'b1, `FKS_OFS_KEY, `FKS_KEY_SECOND, 4'h1);
      bus(1'b1, `FKS_OFS_CTRL, 8'h01, 4'h1);
      mv(16'h1234, 8'h00);
      check("locked_store", {24'h0, fks_flash_model_i.mem[18'h01234]}, {24'h0, old});
    end
    conclude();
  end
endmodule
`default_nettype wire
